// file: include/ltb_pkg.sv
package ltb_pkg;

  // ==========================================================
  // clock and time bases
  localparam int unsigned CLK_HZ     = 50_000_000;
  localparam int unsigned TICK_HZ    = 24_000_000;
  localparam int unsigned RATE_GCD   = 2_000_000;
  localparam logic [5:0]  TICK_NUM   = 6'(TICK_HZ / RATE_GCD);
  localparam logic [5:0]  TICK_DEN   = 6'(CLK_HZ / RATE_GCD);
  localparam int unsigned MS_PER_S   = 1000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / MS_PER_S;
  localparam int unsigned WORD_W     = 32;

  // ==========================================================
  // bus constants and register offsets
  localparam logic [2:0] HSIZE_WORD      = 3'h2;
  localparam logic [7:0] ADDR_CTRL       = 8'h00;
  localparam logic [7:0] ADDR_CONV_IN    = 8'h04;
  localparam logic [7:0] ADDR_CONV_OUT   = 8'h08;
  localparam logic [7:0] ADDR_PRE_OFF    = 8'h0C;
  localparam logic [7:0] ADDR_PRE_ON     = 8'h10;
  localparam logic [7:0] ADDR_PRE_PULSE  = 8'h14;
  localparam logic [7:0] ADDR_ET_OFF     = 8'h18;
  localparam logic [7:0] ADDR_ET_ON      = 8'h1C;
  localparam logic [7:0] ADDR_ET_PULSE   = 8'h20;
  localparam logic [7:0] ADDR_STATUS     = 8'h24;
  localparam logic [7:0] ADDR_COUNT_VAL  = 8'h28;
  localparam logic [7:0] ADDR_HIGH_SPAN  = 8'h2C;
  localparam logic [7:0] ADDR_LOW_SPAN   = 8'h30;

  // ==========================================================
  // field positions and reset values
  localparam int CTL_CONV_EN   = 0;
  localparam int CTL_CAP_EN    = 1;
  localparam int CTL_CAP_CLR   = 2;
  localparam int CTL_CAP_MODE  = 4;
  localparam int CTL_CONV_TYPE = 6;
  localparam int CTL_TRIG      = 8;
  localparam int ST_CONV       = 0;
  localparam int ST_CAP        = 1;
  localparam int ST_TIMER      = 2;
  localparam logic [31:0] WORD_RST  = 32'h0000_0000;
  localparam logic [7:0]  REAL_BIAS = 8'h7F;

  // ==========================================================
  // modes
  typedef enum logic [1:0] {CT_INT = 2'h0, CT_REAL = 2'h1, CT_TIMER = 2'h2} ltb_ctype_type;
  typedef enum logic [1:0] {
    CM_TIMER = 2'h0, CM_FREE = 2'h1, CM_COUNT = 2'h2, CM_DUTY = 2'h3
  } ltb_cmode_type;
  typedef enum logic [2:0] {TM_OFF = 3'h1, TM_ON = 3'h2, TM_PULSE = 3'h4} ltb_tmode_type;

endpackage : ltb_pkg

// file: hdl/ltb_delay_timer.sv
`timescale 1ns/100ps
module ltb_delay_timer
  import ltb_pkg::*;
#(
  parameter ltb_tmode_type MODE = TM_OFF,
  parameter int unsigned   TW   = WORD_W
) (
  input  wire logic          clk_in,
  input  wire logic          rst_n_in,
  input  wire logic          trig_in,
  input  wire logic          tick_in,
  input  wire logic [TW-1:0] preset_in,
  output logic               q_out,
  output logic [TW-1:0]      et_out
);

  logic          q_r, q_nxt, trig_d_r, due;
  logic [TW-1:0] et_r, et_nxt, step;

  // ==========================================================
  // timing
  always_comb begin
    q_nxt = q_r;
    et_nxt = et_r;
    due = et_r >= preset_in;
    // stop at preset rather than wrap
    step = (tick_in && !due) ? TW'(et_r + 1'b1) : et_r;
    case (MODE)
      TM_OFF: begin
        if (trig_in) begin
          q_nxt = 1'b1;
          et_nxt = '0;
        end else if (q_r) begin
          et_nxt = step;
          if (due) q_nxt = 1'b0;
        end
      end
      TM_ON: begin
        if (!trig_in) begin
          q_nxt = 1'b0;
          et_nxt = '0;
        end else begin
          et_nxt = step;
          q_nxt = due;
        end
      end
      TM_PULSE: begin
        if (q_r) begin
          et_nxt = step;
          if (due) q_nxt = 1'b0;
        end else if (trig_in && !trig_d_r && et_r == '0) begin
          q_nxt = 1'b1;
        end else if (due && !trig_in) begin
          et_nxt = '0;
        end
      end
      default: ;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q_r <= 1'b0;
      et_r <= '0;
      trig_d_r <= 1'b0;
    end else begin
      q_r <= q_nxt;
      et_r <= et_nxt;
      trig_d_r <= trig_in;
    end
  end

  assign q_out = q_r;
  assign et_out = et_r;

  // ==========================================================
  // checks
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  a_off_hold_true: assert property (
    (MODE == TM_OFF) && trig_in |=> q_r) else $error("off delay dropped while triggered");
  a_off_expiry: assert property (
    (MODE == TM_OFF) && !trig_in && q_r && due |=> !q_r) else $error("off delay late");
  a_off_restart: assert property (
    (MODE == TM_OFF) && trig_in |=> et_r == '0) else $error("off delay not restarted");
  a_on_reach: assert property (
    (MODE == TM_ON) && trig_in && due |=> q_r) else $error("on delay missed preset");
  a_on_drop: assert property (
    (MODE == TM_ON) && !trig_in |=> !q_r && et_r == '0) else $error("on delay not cleared");
  a_pulse_start: assert property (
    (MODE == TM_PULSE) && $rose(trig_in) && !q_r && et_r == '0 |=> q_r)
    else $error("pulse not started");
  a_pulse_keep: assert property (
    (MODE == TM_PULSE) && q_r && !due |=> q_r) else $error("pulse cut short");
  a_et_tick_only: assert property (
    et_r != $past(et_r) && et_r != '0 |-> $past(tick_in)) else $error("et moved without tick");
  a_et_saturate: assert property (
    due && $stable(preset_in) |=> et_r <= $past(et_r)) else $error("et counted past preset");

endmodule : ltb_delay_timer

// file: hdl/ltb_capture.sv
`timescale 1ns/100ps
module ltb_capture
  import ltb_pkg::*;
#(
  parameter int unsigned CW = WORD_W
) (
  input  wire logic          clk_in,
  input  wire logic          rst_n_in,
  input  wire logic          pin_in,
  input  wire logic          tick_in,
  input  wire logic          en_in,
  input  wire logic          clear_in,
  input  wire ltb_cmode_type mode_in,
  output logic               q_out,
  output logic [CW-1:0]      count_value_out,
  output logic [CW-1:0]      high_span_out,
  output logic [CW-1:0]      low_span_out
);

  logic          q_r, pin_d_r, rise, fall;
  logic [CW-1:0] run_r, run_nxt, run_now, cv_r, cv_nxt, hs_r, hs_nxt, ls_r, ls_nxt;

  function automatic logic [CW-1:0] ltb_sat_inc(input logic [CW-1:0] v);
    return (&v) ? v : CW'(v + 1'b1);
  endfunction : ltb_sat_inc

  // ==========================================================
  // measurement
  always_comb begin
    run_nxt = run_r;
    cv_nxt = cv_r;
    hs_nxt = hs_r;
    ls_nxt = ls_r;
    rise = pin_in && !pin_d_r;
    fall = !pin_in && pin_d_r;
    // a tick on the edge cycle still belongs to the span it closes
    run_now = tick_in ? ltb_sat_inc(run_r) : run_r;
    if (clear_in) begin
      run_nxt = '0;
      cv_nxt = '0;
      hs_nxt = '0;
      ls_nxt = '0;
    end else if (en_in) begin
      case (mode_in)
        CM_TIMER: begin
          if (rise) begin
            cv_nxt = run_now;
            run_nxt = '0;
          end else run_nxt = run_now;
        end
        CM_FREE: if (tick_in) cv_nxt = ltb_sat_inc(cv_r);
        CM_COUNT: if (rise) cv_nxt = ltb_sat_inc(cv_r);
        CM_DUTY: begin
          if (rise) begin
            ls_nxt = run_now;
            cv_nxt = CW'(hs_r + run_now);
            run_nxt = '0;
          end else if (fall) begin
            hs_nxt = run_now;
            run_nxt = '0;
          end else run_nxt = run_now;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q_r <= 1'b0;
      pin_d_r <= 1'b0;
      run_r <= '0;
      cv_r <= '0;
      hs_r <= '0;
      ls_r <= '0;
    end else begin
      q_r <= en_in;
      pin_d_r <= pin_in;
      run_r <= run_nxt;
      cv_r <= cv_nxt;
      hs_r <= hs_nxt;
      ls_r <= ls_nxt;
    end
  end

  assign q_out = q_r;
  assign count_value_out = cv_r;
  assign high_span_out = hs_r;
  assign low_span_out = ls_r;

  // ==========================================================
  // checks
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  a_cap_status: assert property (
    en_in ##1 en_in |-> q_r) else $error("capture status low while enabled");
  a_cap_clear: assert property (
    clear_in |=> cv_r == '0 && hs_r == '0 && ls_r == '0) else $error("capture not cleared");
  a_duty_only: assert property (
    !clear_in && mode_in != CM_DUTY |=> $stable(hs_r) && $stable(ls_r))
    else $error("spans moved outside duty mode");
  a_free_ticks: assert property (
    en_in && !clear_in && mode_in == CM_FREE && !(&cv_r) |=> cv_r == $past(cv_r) + $past(tick_in))
    else $error("free count not tick based");

endmodule : ltb_capture

// file: hdl/ltb_top.sv
`timescale 1ns/100ps
module ltb_top
  import ltb_pkg::*;
#(
  parameter int unsigned MS_CYCLES = CYC_PER_MS
) (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        hsel_in,
  input  wire logic [7:0]  haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  input  wire logic        cap_pin_in,
  output logic             conv_q_out,
  output logic             cap_q_out,
  output logic             off_q_out,
  output logic             on_q_out,
  output logic             pulse_q_out
);

  localparam ltb_tmode_type TMODES [3] = '{TM_OFF, TM_ON, TM_PULSE};

  // ==========================================================
  // bus slave
  logic        acc, wr_pend_r, wr_pend_nxt, rd_pend_r, rd_pend_nxt;
  logic        hready_r, hready_nxt;
  logic [7:0]  addr_r, addr_nxt;
  logic [31:0] hrdata_r, hrdata_nxt, rd_mux;

  assign acc = hsel_in && htrans_in[1] && hready_in;

  // reads take one wait state so a write just before is already visible
  always_comb begin
    wr_pend_nxt = acc && hwrite_in && (hsize_in == HSIZE_WORD);
    rd_pend_nxt = acc && !hwrite_in;
    addr_nxt = acc ? haddr_in : addr_r;
    hready_nxt = !rd_pend_nxt;
    hrdata_nxt = rd_pend_r ? rd_mux : hrdata_r;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      hready_r <= 1'b1;
      addr_r <= 8'h00;
      hrdata_r <= WORD_RST;
      hresp_out <= 1'b0;
    end else begin
      wr_pend_r <= wr_pend_nxt;
      rd_pend_r <= rd_pend_nxt;
      hready_r <= hready_nxt;
      addr_r <= addr_nxt;
      hrdata_r <= hrdata_nxt;
      hresp_out <= 1'b0;
    end
  end

  assign hreadyout_out = hready_r;
  assign hrdata_out = hrdata_r;

  // ==========================================================
  // control registers
  logic          conv_en_r, conv_en_nxt, cap_en_r, cap_en_nxt, cap_clr_r, cap_clr_nxt;
  logic [2:0]    trig_r, trig_nxt;
  ltb_cmode_type cap_mode_r, cap_mode_nxt;
  ltb_ctype_type conv_type_r, conv_type_nxt;
  logic [31:0]   conv_in_r, conv_in_nxt;
  logic [31:0]   preset_r [3];
  logic [31:0]   preset_nxt [3];

  always_comb begin
    conv_en_nxt = conv_en_r;
    cap_en_nxt = cap_en_r;
    cap_clr_nxt = cap_clr_r;
    trig_nxt = trig_r;
    cap_mode_nxt = cap_mode_r;
    conv_type_nxt = conv_type_r;
    conv_in_nxt = conv_in_r;
    preset_nxt = preset_r;
    if (wr_pend_r) begin
      case (addr_r)
        ADDR_CTRL: begin
          conv_en_nxt = hwdata_in[CTL_CONV_EN];
          cap_en_nxt = hwdata_in[CTL_CAP_EN];
          cap_clr_nxt = hwdata_in[CTL_CAP_CLR];
          trig_nxt = hwdata_in[CTL_TRIG +: 3];
          conv_type_nxt = ltb_ctype_type'(hwdata_in[CTL_CONV_TYPE +: 2]);
          // mode may only change while the reader is stopped
          if (!cap_en_r) begin
            cap_mode_nxt = ltb_cmode_type'(hwdata_in[CTL_CAP_MODE +: 2]);
          end
        end
        ADDR_CONV_IN: conv_in_nxt = hwdata_in;
        ADDR_PRE_OFF: preset_nxt[0] = hwdata_in;
        ADDR_PRE_ON: preset_nxt[1] = hwdata_in;
        ADDR_PRE_PULSE: preset_nxt[2] = hwdata_in;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      conv_en_r <= 1'b0;
      cap_en_r <= 1'b0;
      cap_clr_r <= 1'b0;
      trig_r <= 3'h0;
      cap_mode_r <= CM_TIMER;
      conv_type_r <= CT_INT;
      conv_in_r <= WORD_RST;
      preset_r <= '{WORD_RST, WORD_RST, WORD_RST};
    end else begin
      conv_en_r <= conv_en_nxt;
      cap_en_r <= cap_en_nxt;
      cap_clr_r <= cap_clr_nxt;
      trig_r <= trig_nxt;
      cap_mode_r <= cap_mode_nxt;
      conv_type_r <= conv_type_nxt;
      conv_in_r <= conv_in_nxt;
      preset_r <= preset_nxt;
    end
  end

  // ==========================================================
  // value to timer converter
  logic        conv_q_r;
  logic [31:0] conv_out_r, conv_out_nxt, conv_val;

  // truncates toward zero; negatives give zero, overflow saturates
  function automatic logic [31:0] ltb_real_to_ms(input logic [31:0] f);
    logic [63:0] w;
    logic [7:0]  e;
    w = '0;
    e = f[30:23];
    if (f[31] || e < REAL_BIAS) return '0;
    if (e > REAL_BIAS + 8'd31) return '1;
    w = 64'({1'b1, f[22:0]}) << (e - REAL_BIAS);
    return w[54:23];
  endfunction : ltb_real_to_ms

  always_comb begin
    case (conv_type_r)
      CT_REAL: conv_val = ltb_real_to_ms(conv_in_r);
      CT_TIMER: conv_val = conv_in_r;
      default: conv_val = conv_in_r[31] ? WORD_RST : conv_in_r;
    endcase
    conv_out_nxt = conv_en_r ? conv_val : conv_out_r;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      conv_q_r <= 1'b0;
      conv_out_r <= WORD_RST;
    end else begin
      conv_q_r <= conv_en_r;
      conv_out_r <= conv_out_nxt;
    end
  end

  assign conv_q_out = conv_q_r;

  // ==========================================================
  // time bases and pin synchroniser
  logic [5:0]  acc24_r, acc24_nxt, acc24_sum;
  logic        tick24_r, tick24_nxt, ms_tick_r, ms_tick_nxt, sync1_r, sync2_r;
  logic [31:0] ms_cnt_r, ms_cnt_nxt;

  // fractional divider: 12 ticks every 25 clocks, jitter of one clock
  always_comb begin
    acc24_sum = acc24_r + TICK_NUM;
    tick24_nxt = acc24_sum >= TICK_DEN;
    acc24_nxt = tick24_nxt ? 6'(acc24_sum - TICK_DEN) : acc24_sum;
    ms_tick_nxt = ms_cnt_r == 32'(MS_CYCLES - 1);
    ms_cnt_nxt = ms_tick_nxt ? 32'h0000_0000 : ms_cnt_r + 32'h0000_0001;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      acc24_r <= TICK_DEN - TICK_NUM;  // first tick early, no long gap after reset
      tick24_r <= 1'b0;
      ms_cnt_r <= 32'h0000_0000;
      ms_tick_r <= 1'b0;
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      acc24_r <= acc24_nxt;
      tick24_r <= tick24_nxt;
      ms_cnt_r <= ms_cnt_nxt;
      ms_tick_r <= ms_tick_nxt;
      sync1_r <= cap_pin_in;
      sync2_r <= sync1_r;
    end
  end

  // ==========================================================
  // capture reader and timers
  logic [31:0] cv_w, hs_w, ls_w;
  logic [31:0] et_w [3];
  logic [2:0]  tq_w;

  ltb_capture #(
    .CW (WORD_W)
  ) u_capture (
    .clk_in          (clk_in),
    .rst_n_in        (rst_n_in),
    .pin_in          (sync2_r),
    .tick_in         (tick24_r),
    .en_in           (cap_en_r),
    .clear_in        (cap_clr_r),
    .mode_in         (cap_mode_r),
    .q_out           (cap_q_out),
    .count_value_out (cv_w),
    .high_span_out   (hs_w),
    .low_span_out    (ls_w)
  );

  for (genvar i = 0; i < 3; i++) begin : g_timer
    ltb_delay_timer #(
      .MODE (TMODES[i]),
      .TW   (WORD_W)
    ) u_timer (
      .clk_in    (clk_in),
      .rst_n_in  (rst_n_in),
      .trig_in   (trig_r[i]),
      .tick_in   (ms_tick_r),
      .preset_in (preset_r[i]),
      .q_out     (tq_w[i]),
      .et_out    (et_w[i])
    );
  end

  assign off_q_out = tq_w[0];
  assign on_q_out = tq_w[1];
  assign pulse_q_out = tq_w[2];

  // ==========================================================
  // read mux, unmapped reads as zero
  always_comb begin
    rd_mux = WORD_RST;
    case (addr_r)
      ADDR_CTRL: begin
        rd_mux[CTL_CONV_EN] = conv_en_r;
        rd_mux[CTL_CAP_EN] = cap_en_r;
        rd_mux[CTL_CAP_CLR] = cap_clr_r;
        rd_mux[CTL_CAP_MODE +: 2] = cap_mode_r;
        rd_mux[CTL_CONV_TYPE +: 2] = conv_type_r;
        rd_mux[CTL_TRIG +: 3] = trig_r;
      end
      ADDR_STATUS: begin
        rd_mux[ST_CONV] = conv_q_r;
        rd_mux[ST_CAP] = cap_q_out;
        rd_mux[ST_TIMER +: 3] = tq_w;
      end
      ADDR_CONV_IN: rd_mux = conv_in_r;
      ADDR_CONV_OUT: rd_mux = conv_out_r;
      ADDR_PRE_OFF: rd_mux = preset_r[0];
      ADDR_PRE_ON: rd_mux = preset_r[1];
      ADDR_PRE_PULSE: rd_mux = preset_r[2];
      ADDR_ET_OFF: rd_mux = et_w[0];
      ADDR_ET_ON: rd_mux = et_w[1];
      ADDR_ET_PULSE: rd_mux = et_w[2];
      ADDR_COUNT_VAL: rd_mux = cv_w;
      ADDR_HIGH_SPAN: rd_mux = hs_w;
      ADDR_LOW_SPAN: rd_mux = ls_w;
      default: ;
    endcase
  end

  // ==========================================================
  // checks
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  a_conv_int_ms: assert property (
    conv_en_r && conv_type_r == CT_INT && !conv_in_r[31] |=> conv_out_r == $past(conv_in_r))
    else $error("integer not passed as ms");
  a_conv_status: assert property (
    conv_en_r ##1 !conv_en_r |=> !conv_q_r) else $error("converter status stuck");
  a_conv_timer_copy: assert property (
    conv_en_r && conv_type_r == CT_TIMER |=> conv_out_r == $past(conv_in_r))
    else $error("timer copy altered");
  a_mode_locked: assert property (
    cap_en_r |=> $stable(cap_mode_r)) else $error("mode changed while running");
  a_tick_spacing: assert property (
    tick24_r |=> !tick24_r) else $error("24 MHz tick too dense");
  a_tick_gap: assert property (
    !tick24_r [*3] |-> 1'b0) else $error("24 MHz tick gap too long");
  a_read_wait: assert property (
    acc && !hwrite_in |=> !hready_r ##1 hready_r) else $error("read wait state wrong");

endmodule : ltb_top

// file: sim/ltb_pulse_src.sv
`timescale 1ns/100ps
module ltb_pulse_src (
  input  wire logic       clk_in,
  input  wire logic       run_in,
  input  wire logic [7:0] hi_in,
  input  wire logic [7:0] lo_in,
  output logic            pin_out
);
  // ==========================================================
  // square wave on the capture pin, low and still when idle
  initial pin_out = 1'b0;
  always begin
    @(posedge clk_in);
    if (run_in) begin
      pin_out <= 1'b1;
      repeat (hi_in) @(posedge clk_in);
      pin_out <= 1'b0;
      repeat (lo_in - 8'h01) @(posedge clk_in);
    end
  end
endmodule : ltb_pulse_src

// file: sim/ladder_timer_blocks_tb_top.sv
`timescale 1ns/100ps
module ladder_timer_blocks_tb_top;
  import ltb_pkg::*;
  logic        clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic        run = 1'b0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic        hready;
  logic        hresp;
  logic        cap_pin;
  wire logic [4:0] qv;
  int          error_cnt = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          edges = 0;

  ltb_top #(.MS_CYCLES(10)) dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(HSIZE_WORD),
    .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
    .hresp_out(hresp), .cap_pin_in(cap_pin), .conv_q_out(qv[0]), .cap_q_out(qv[1]),
    .off_q_out(qv[2]), .on_q_out(qv[3]), .pulse_q_out(qv[4]));
  // 50 clocks high, 25 low: exactly 24 and 12 ticks at a 12/25 tick rate
  ltb_pulse_src u_src (.clk_in(clk_in), .run_in(run), .hi_in(8'h32), .lo_in(8'h19),
    .pin_out(cap_pin));

  always #10 clk_in = ~clk_in;
  always @(posedge cap_pin) edges++;
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end

  // ==========================================================
  // shared tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= a;
    do @(posedge clk_in); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_in); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic wait_q(input int i, input logic v, input int lo, input int hi);
    int n;
    n = 0;
    while (qv[i] !== v && n < hi) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    chk("q delay", 32'(n >= lo && n < hi), 32'h1);
  endtask : wait_q

  // ==========================================================
  // scenarios
  task automatic t_reset();
    logic [7:0] ad[4] = '{ADDR_CTRL, ADDR_STATUS, ADDR_ET_ON, 8'h3C};
    foreach (ad[i]) begin
      bus(1'b0, ad[i], 32'h0);
      chk("reset read", rd, WORD_RST);
    end
    chk("hresp", 32'(hresp), 32'h0);
  endtask : t_reset
  task automatic t_conv();
    logic [31:0] tin[3] = '{32'h0000_0005, 32'h447A_0000, 32'hFFFF_FFF0};
    logic [31:0] tex[3] = '{32'h0000_0005, 32'h0000_03E8, 32'hFFFF_FFF0};
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, ADDR_CONV_IN, tin[i]);
      bus(1'b1, ADDR_CTRL, (32'(i) << CTL_CONV_TYPE) | 32'h1);
      bus(1'b0, ADDR_CONV_OUT, 32'h0);
      chk("conv out", rd, tex[i]);
      chk("conv q on", 32'(qv[0]), 32'h1);
    end
    bus(1'b1, ADDR_CTRL, 32'h0);
    repeat (2) @(posedge clk_in);
    chk("conv q off", 32'(qv[0]), 32'h0);
  endtask : t_conv
  task automatic t_capture();
    logic [31:0] md[4] = '{32'h00, 32'h10, 32'h20, 32'h30};
    for (int i = 0; i < 4; i++) begin
      // mode is only taken while disabled
      bus(1'b1, ADDR_CTRL, md[i] | 32'h4);
      bus(1'b1, ADDR_CTRL, md[i] | 32'h2);
      edges = 0;
      run <= 1'b1;
      repeat (300) @(posedge clk_in);
      run <= 1'b0;
      repeat (100) @(posedge clk_in);
      chk("cap q", 32'(qv[1]), 32'h1);
      bus(1'b0, ADDR_COUNT_VAL, 32'h0);
      if (i == 0) chk("timer mode", rd, 32'd36);
      // about 402 enabled clocks at 12 ticks per 25 clocks
      if (i == 1) chk("free mode", 32'(rd >= 32'd192 && rd <= 32'd194), 32'h1);
      if (i == 2) chk("count mode", rd, 32'(edges));
      if (i == 3) chk("duty sum", rd, 32'd36);
    end
    bus(1'b0, ADDR_HIGH_SPAN, 32'h0);
    chk("high span", rd, 32'd24);
    bus(1'b0, ADDR_LOW_SPAN, 32'h0);
    chk("low span", rd, 32'd12);
    bus(1'b1, ADDR_CTRL, 32'h06);
    bus(1'b0, ADDR_CTRL, 32'h0);
    chk("mode locked", rd, 32'h36);
    bus(1'b0, ADDR_HIGH_SPAN, 32'h0);
    chk("clear", rd, 32'h0);
    bus(1'b1, ADDR_CTRL, 32'h0);
    repeat (2) @(posedge clk_in);
    chk("cap q off", 32'(qv[1]), 32'h0);
  endtask : t_capture
  task automatic t_off();
    bus(1'b1, ADDR_PRE_OFF, 32'h3);
    bus(1'b1, ADDR_CTRL, 32'h100);
    wait_q(2, 1'b1, 0, 4);
    bus(1'b1, ADDR_CTRL, 32'h0);
    repeat (12) @(posedge clk_in);
    bus(1'b1, ADDR_CTRL, 32'h100);
    bus(1'b1, ADDR_CTRL, 32'h0);
    wait_q(2, 1'b0, 18, 40);
    bus(1'b0, ADDR_ET_OFF, 32'h0);
    chk("off et", rd, 32'h3);
  endtask : t_off
  task automatic t_on();
    bus(1'b1, ADDR_PRE_ON, 32'h3);
    bus(1'b1, ADDR_CTRL, 32'h200);
    wait_q(3, 1'b1, 18, 40);
    repeat (30) @(posedge clk_in);
    bus(1'b0, ADDR_ET_ON, 32'h0);
    chk("on et held", rd, 32'h3);
    bus(1'b1, ADDR_CTRL, 32'h0);
    wait_q(3, 1'b0, 0, 3);
    bus(1'b0, ADDR_ET_ON, 32'h0);
    chk("on et clear", rd, 32'h0);
  endtask : t_on
  task automatic t_pulse();
    bus(1'b1, ADDR_PRE_PULSE, 32'h4);
    bus(1'b1, ADDR_CTRL, 32'h400);
    bus(1'b1, ADDR_CTRL, 32'h0);
    chk("pulse q", 32'(qv[4]), 32'h1);
    wait_q(4, 1'b0, 20, 45);
    bus(1'b0, ADDR_ET_PULSE, 32'h0);
    chk("pulse et", rd, 32'h0);
  endtask : t_pulse

  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_conv();
    t_capture();
    t_off();
    t_on();
    t_pulse();
    complete_run();
  end
endmodule : ladder_timer_blocks_tb_top
